// ==== dv/acl_codec_model.sv ====
// codecs and board straps on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module acl_codec_model (
  input  wire logic       codec_reset_n_i,
  input  wire logic       fs_drv_i,
  input  wire logic       fs_oe_i,
  input  wire logic       so_drv_i,
  input  wire logic       so_oe_i,
  input  wire logic [1:0] strap_i,
  input  wire logic [2:0] lanes_i,
  output logic            fs_pin_o,
  output logic            so_pin_o,
  output logic [2:0]      serial_in_o
);
  assign fs_pin_o = fs_oe_i ? fs_drv_i : strap_i[1];
  assign so_pin_o = so_oe_i ? so_drv_i : strap_i[0];
  // codecs in reset release lanes: inverse level
  assign serial_in_o = codec_reset_n_i ? lanes_i : ~lanes_i;
endmodule // acl_codec_model
`default_nettype wire

// ==== dv/acl_link_chk.sv ====
// assertions on the ports of the codec link block
`timescale 1ns/100ps
`default_nettype none
module acl_link_chk #(
  parameter HALF       = 1,
  parameter FRAME_BCLK = 40
) (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       power_good_i,
  input wire logic       link_enable_i,
  input wire logic [3:0] stream_id_i,
  input wire logic       frame_sync_i,
  input wire logic       serial_out_i,
  input wire logic       frame_sync_o,
  input wire logic       frame_sync_oe_o,
  input wire logic       serial_out_oe_o,
  input wire logic       codec_reset_n_o,
  input wire logic       link_bit_clock_o,
  input wire logic       rx_valid_o,
  input wire logic [4:0] lane_x4_o
);
  localparam int GAP = 2*FRAME_BCLK*HALF - 9;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // long idle, eight-clock mark, two-clock gap
  sequence s_mark;
    (!frame_sync_o)[*4] ##1 frame_sync_o[*8] ##1 (!frame_sync_o)[*2];
  endsequence
  sequence s_bit(b);
    (frame_sync_o == b)[*2];
  endsequence
  AST_FRAME: assert property (disable iff (!rstn_i || !link_enable_i)
    s_mark |-> ##GAP $rose(frame_sync_o)) else $error("frame sync period wrong");
  AST_TAG: assert property (disable iff (!rstn_i || !link_enable_i)
    s_mark |-> ##1 s_bit(stream_id_i[3]) ##1 s_bit(stream_id_i[2]) ##1 s_bit(stream_id_i[1])
    ##1 s_bit(stream_id_i[0]) ##1 !frame_sync_o) else $error("stream number wrong");
  AST_CH4: assert property (lane_x4_o[4] == 1'b0) else $error("channel 4 not x1");
  AST_UNI: assert property (lane_x4_o[3:0] inside {4'h0, 4'hf}) else $error("lanes differ");
  AST_STRAP: assert property ($rose(lane_x4_o[0]) |-> $past(frame_sync_i && serial_out_i))
    else $error("x4 without straps");
  AST_HOLD: assert property (($stable(power_good_i))[*8] |-> $stable(lane_x4_o))
    else $error("strap moved");
  AST_OE: assert property ((!power_good_i)[*6] |-> !frame_sync_oe_o && !serial_out_oe_o && !codec_reset_n_o)
    else $error("pins driven without power good");
  AST_RST: assert property ((!link_enable_i)[*3] |-> !codec_reset_n_o)
    else $error("codec reset released");
  AST_BCLK: assert property ((codec_reset_n_o && link_enable_i)[*4] |-> $changed(link_bit_clock_o))
    else $error("bit clock stuck");
  AST_RXV: assert property (rx_valid_o |=> (!rx_valid_o)[*8]) else $error("rx word too short");
endmodule // acl_link_chk
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the codec link block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int FRAME = 80; // clocks per frame: 40 bit clocks of two clocks each
  logic clk_i = 0, rstn_i = 0, pg = 0, en = 0, tx_valid = 0, fs_q = 0;
  logic fs_i, so_i, tx_ready, rx_valid, rst_n, fs_o, fs_oe, so_o, so_oe;
  logic [3:0] sid = 0;
  logic [7:0] tx_data = 0, w = 0;
  logic [1:0] strap = 0;
  logic [23:0] rx_data;
  logic [2:0] sin, lanes = 0;
  logic [4:0] lane, e;
  logic [7:0] q[$];
  int n_mismatch = 0, checked = 0, i, p = -1, n_rx = 0;
  always #10 clk_i = ~clk_i;
  acl_link #(.W(8), .HALF(1), .FRAME_BCLK(40)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .power_good_i(pg), .link_enable_i(en), .stream_id_i(sid), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .codec_reset_n_o(rst_n),
    .link_bit_clock_o(), .frame_sync_i(fs_i), .frame_sync_o(fs_o), .frame_sync_oe_o(fs_oe),
    .serial_out_i(so_i), .serial_out_o(so_o), .serial_out_oe_o(so_oe), .serial_in_i(sin), .lane_x4_o(lane));
  acl_codec_model codec (.codec_reset_n_i(rst_n), .fs_drv_i(fs_o), .fs_oe_i(fs_oe), .so_drv_i(so_o),
    .so_oe_i(so_oe), .strap_i(strap), .lanes_i(lanes), .fs_pin_o(fs_i), .so_pin_o(so_i), .serial_in_o(sin));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_tx(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic push(input logic [7:0] d);
    for (i = 0; i < 400 && tx_ready !== 1'b1; i++) tick(1);
    if (tx_ready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end
    tx_data = d;
    tx_valid = 1;
    q.push_back(d);
    tick(1);
    tx_valid = 0;
    tick(1);
  endtask
  // serial words on the wire, one bit per clock, slots counted from frame start;
  // an all-zero word is an empty slot, so the bench sends no zero words
  always @(posedge clk_i) begin
    if (en !== 1'b1) p = -1;
    else if (p < 0 && fs_o === 1'b1 && fs_q === 1'b0) p = 0;
    else if (p >= 0) p = (p + 1) % FRAME;
    fs_q = fs_o;
    if (p >= 0) begin
      w = {w[6:0], so_o};
      if (p == 0) cmp(24'(fs_o), 1);
      if (p % 8 == 7 && w !== 8'h00) cmp_tx(w, (q.size() > 0) ? q.pop_front() : 8'h00);
    end
  end
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      n_rx++;
      cmp(rx_data, {{8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}});
    end
  end
  initial begin
    void'($urandom(32'h4072));
    tick(5);
    rstn_i = 1;
    tick(2);
    for (int s = 0; s < 4; s++) begin
      strap = 2'h3 ^ 2'(s);
      e = (s == 0) ? 5'h0f : 5'h00;
      pg = 1;
      tick(8);
      cmp(lane, e);
      strap = 2'h3 ^ strap;
      pg = 0;
      tick(8);
      cmp(lane, e);
    end
    pg = 1;
    sid = 4'($urandom);
    lanes = 3'($urandom);
    tick(8);
    push(8'($urandom % 255) + 8'h01);
    push(8'($urandom % 255) + 8'h01);
    tick(2);
    cmp(tx_ready, 1'b0);
    en = 1;
    tick(6);
    cmp(rst_n, 1'b1);
    for (int k = 0; k < 8; k++) push(8'($urandom % 255) + 8'h01);
    for (i = 0; i < 3000 && q.size() > 0; i++) tick(1);
    cmp(24'(q.size()), 0);
    cmp(24'(n_rx > 0), 1);
    tick(300);
    en = 0;
    tick(3);
    cmp(rst_n, 1'b0);
    complete_run;
  end
endmodule // testbench
bind acl_link acl_link_chk #(.HALF(HALF), .FRAME_BCLK(FRAME_BCLK)) u_chk (.*);
`default_nettype wire

// ==== src/acl_link.v ====
// host end of a tdm audio codec link with power-good lane-width strap
`timescale 1ns/100ps
`default_nettype none
`include "acl_map.vh"

// Function
// - drive codec reset to all attached codecs
// - frame sync repeats at frame rate
// - frame sync also carries stream number
// - generate bit clock, drive it out
// - serial out changes on both clock edges
// - receive three serial inputs, one bit/clock
// - fixed link framing only, no legacy mode
// - strap x4 when both pins high
// - channel 4 always x1
// - codec reset active low
module acl_link #(
  parameter W          = `ACL_WORD_BITS,
  parameter HALF       = `ACL_BCLK_HALF_CYC,
  parameter FRAME_BCLK = `ACL_FRAME_BCLK
) (
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire             ce_i,
  input  wire             power_good_i,
  input  wire             link_enable_i,
  input  wire [3:0]       stream_id_i,
  input  wire [W-1:0]     tx_data_i,
  input  wire             tx_valid_i,
  output reg              tx_ready_o,
  output reg  [3*W-1:0]   rx_data_o,
  output reg              rx_valid_o,
  output reg              codec_reset_n_o,
  output reg              link_bit_clock_o,
  input  wire             frame_sync_i,
  output reg              frame_sync_o,
  output reg              frame_sync_oe_o,
  input  wire             serial_out_i,
  output reg              serial_out_o,
  output reg              serial_out_oe_o,
  input  wire [2:0]       serial_in_i,
  output reg  [4:0]       lane_x4_o
);

  localparam OBITS = 2 * FRAME_BCLK;
  localparam OW    = 12;
  localparam HW    = 8;
  localparam WC    = 8;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg  [5:0] meta;
  reg  [5:0] sync;
  wire       pg_s   = sync[0];
  wire       fs_s   = sync[1];
  wire       so_s   = sync[2];
  wire [2:0] sin_s  = sync[5:3];
  reg        pg_d;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 6'h00;
      sync <= 6'h00;
      pg_d <= 1'b0;
    end else if (ce_i) begin
      meta <= {serial_in_i, serial_out_i, frame_sync_i, power_good_i};
      sync <= meta;
      pg_d <= pg_s;
    end
  end

  // straps pass the same two flops as power good, so both line up
  wire pg_rise = pg_s & ~pg_d;

  // ****************************************
  // lane-width strap
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lane_x4_o <= `ACL_LANE_RST;
    end else if (ce_i && pg_rise) begin
      lane_x4_o[3:0] <= {4{fs_s & so_s}};
      lane_x4_o[4]   <= 1'b0;
    end
  end

  // ****************************************
  // codec reset and pin direction
  // ****************************************
  // pins stay released before power good so the board straps can be read
  reg run;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      codec_reset_n_o <= 1'b0;
      frame_sync_oe_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
      run             <= 1'b0;
    end else if (ce_i) begin
      codec_reset_n_o <= pg_d & link_enable_i;
      frame_sync_oe_o <= pg_d;
      serial_out_oe_o <= pg_d;
      run             <= pg_d & link_enable_i & codec_reset_n_o;
    end
  end

  // ****************************************
  // bit clock and frame position
  // ****************************************
  // bit clock parks low while the link is stopped
  reg  [HW-1:0] hcnt;
  reg  [OW-1:0] obit;
  wire          tick  = run && (hcnt == HALF[HW-1:0] - 8'h01);
  wire          rise  = tick & ~link_bit_clock_o;
  wire          olast = (obit == OBITS[OW-1:0] - 12'h001);
  wire [OW-2:0] bpos  = obit[OW-1:1];

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hcnt             <= 8'h00;
      obit             <= 12'h000;
      link_bit_clock_o <= 1'b0;
    end else if (ce_i) begin
      if (!run) begin
        hcnt             <= 8'h00;
        obit             <= 12'h000;
        link_bit_clock_o <= 1'b0;
      end else if (tick) begin
        hcnt             <= 8'h00;
        link_bit_clock_o <= ~link_bit_clock_o;
        obit             <= olast ? 12'h000 : obit + 12'h001;
      end else begin
        hcnt <= hcnt + 8'h01;
      end
    end
  end

  // ****************************************
  // frame sync: mark, gap, stream number
  // ****************************************
  // sized copies of the layout constants, so no sum is cut silently
  localparam [OW-2:0] TAG_LO = `ACL_TAG_POS;
  localparam [OW-2:0] TAG_HI = `ACL_TAG_POS + `ACL_TAG_BITS;

  reg  [3:0]    tag;
  wire [OW-2:0] tag_end = TAG_HI;
  wire [OW-2:0] tag_idx = bpos - TAG_LO;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_sync_o <= 1'b0;
      tag          <= 4'h0;
    end else if (ce_i) begin
      if (!run) begin
        frame_sync_o <= 1'b0;
      end else if (rise) begin
        if (obit == 12'h000)
          tag <= stream_id_i;
        if (bpos < `ACL_SYNC_MARK_LEN)
          frame_sync_o <= 1'b1;
        else if (bpos >= `ACL_TAG_POS && bpos < tag_end)
          frame_sync_o <= tag[3 - tag_idx[1:0]];
        else
          frame_sync_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // two-entry transmit buffer
  // ****************************************
  reg  [W-1:0] mem0;
  reg  [W-1:0] mem1;
  reg          wptr;
  reg          rptr;
  reg  [1:0]   cnt;
  wire         push = tx_valid_i & tx_ready_o;
  wire         pop;
  reg  [1:0]   next_cnt;
  // ready is registered from next_cnt: it drops on the same edge that stores the second word

  always @* begin
    next_cnt = cnt;
    if (push && !pop)
      next_cnt = cnt + 2'h1;
    else if (pop && !push)
      next_cnt = cnt - 2'h1;
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem0       <= {W{1'b0}};
      mem1       <= {W{1'b0}};
      wptr       <= 1'b0;
      rptr       <= 1'b0;
      cnt        <= 2'h0;
      tx_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        if (wptr)
          mem1 <= tx_data_i;
        else
          mem0 <= tx_data_i;
        wptr <= ~wptr;
      end
      if (pop)
        rptr <= ~rptr;
      cnt        <= next_cnt;
      tx_ready_o <= (next_cnt != 2'h2);
    end
  end

  // ****************************************
  // serialiser, one bit per bit-clock edge
  // ****************************************
  reg  [W-1:0]  tx_sh;
  reg  [WC-1:0] wcnt;
  wire          wstart = (wcnt == 8'h00);
  wire          wwrap  = olast | (wcnt == W[WC-1:0] - 8'h01);
  // a word leaves only at a slot start; an empty slot sends zeros
  assign pop = tick & wstart & (cnt != 2'h0);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_sh        <= {W{1'b0}};
      wcnt         <= 8'h00;
      serial_out_o <= 1'b0;
    end else if (ce_i) begin
      if (!run) begin
        wcnt         <= 8'h00;
        serial_out_o <= 1'b0;
      end else if (tick) begin
        wcnt <= wwrap ? 8'h00 : wcnt + 8'h01;
        if (wstart) begin
          if (cnt != 2'h0) begin
            serial_out_o <= rptr ? mem1[W-1] : mem0[W-1];
            tx_sh        <= (rptr ? mem1 : mem0) << 1;
          end else begin
            serial_out_o <= 1'b0;
            tx_sh        <= {W{1'b0}};
          end
        end else begin
          serial_out_o <= tx_sh[W-1];
          tx_sh        <= tx_sh << 1;
        end
      end
    end
  end

  // ****************************************
  // receiver, three lanes
  // ****************************************
  reg  [1:0]    rise_d;
  reg  [1:0]    fstart_d;
  reg  [WC-1:0] rcnt;
  wire          samp  = rise_d[1];
  wire          rlast = (rcnt == W[WC-1:0] - 8'h01);
  wire [3*W-1:0] rx_sh;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_d     <= 2'h0;
      fstart_d   <= 2'h0;
      rcnt       <= 8'h00;
      rx_data_o  <= {3*W{1'b0}};
      rx_valid_o <= 1'b0;
    end else if (ce_i) begin
      rise_d     <= {rise_d[0], rise};
      fstart_d   <= {fstart_d[0], rise & (obit == 12'h000)};
      rx_valid_o <= 1'b0;
      if (samp) begin
        // the frame-start sample is bit 0, even when a word was cut short
        if (fstart_d[1])
          rcnt <= 8'h01;
        else if (rlast)
          rcnt <= 8'h00;
        else
          rcnt <= rcnt + 8'h01;
        if (rlast && !fstart_d[1]) begin
          rx_data_o  <= rx_sh;
          rx_valid_o <= 1'b1;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_lane
      reg [W-1:0] sh;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
          sh <= {W{1'b0}};
        else if (ce_i && samp)
          sh <= {sh[W-2:0], sin_s[g]};
      end
      assign rx_sh[g*W +: W] = {sh[W-2:0], sin_s[g]};
    end
  endgenerate

endmodule // acl_link
`default_nettype wire

// ==== src/acl_map.vh ====
// constants for the audio codec link with lane-width strap
`ifndef ACL_MAP_VH
`define ACL_MAP_VH

// ****************************************
// timing
// ****************************************
`define ACL_CLK_KHZ        50000
`define ACL_BCLK_KHZ       24000
`define ACL_FRAME_HZ       48000
`define ACL_BCLK_HALF_CYC  (`ACL_CLK_KHZ / (2 * `ACL_BCLK_KHZ))
`define ACL_FRAME_BCLK     ((`ACL_BCLK_KHZ * 1000) / `ACL_FRAME_HZ)

// ****************************************
// frame sync layout, in bit-clock periods
// ****************************************
`define ACL_SYNC_MARK_LEN  4
`define ACL_TAG_POS        5
`define ACL_TAG_BITS       4

// ****************************************
// reset values and word width
// ****************************************
`define ACL_LANE_RST       5'h00
`define ACL_WORD_BITS      16

`endif
